// File: include/fsuc_cfg.svh
/*
  constants for the fan spin-up and test mode control block.
  assumes inclusion by bare name from design files.
*/
`ifndef FSUC_CFG_SVH
`define FSUC_CFG_SVH
`define FSUC_ADDR_TEST 8'h6F
`define FSUC_ADDR_SPINUP 8'h75
`define FSUC_SPINUP_RESET 8'h07
`define FSUC_TEST_RESET 8'h00
`define FSUC_UNDEF_READ 8'h00
`define FSUC_XEN_BIT 0
`define FSUC_SPINUP_MASK 8'h07
`define FSUC_CHANNELS 3
`endif

// File: include/fsuc_pkg.sv
/*
  types for the fan spin-up and test mode control block.
  assumes no other package.
*/
package fsuc_pkg;
  typedef enum logic [2:0] {
    FSUC_IDLE = 3'b001,
    FSUC_SPIN = 3'b010,
    FSUC_RUN = 3'b100
  } fsuc_state_t;
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } fsuc_regreq_t;
endpackage

// File: hw/fsuc_spin_chan.sv
/*
  one channel of spin-up termination: spin duty until timeout or tach threshold.
  assumes a timer length and tach values from the fan configuration logic.
*/
`timescale 1ns/10ps
`include "fsuc_cfg.svh"
module fsuc_spin_chan (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic spinStart,
  input wire logic earlyExit,
  input wire logic [15:0] spinCycles,
  input wire logic [15:0] tachReading,
  input wire logic [15:0] tachMinimum,
  output logic spinActive
);
  fsuc_pkg::fsuc_state_t state_r, state_nxt;
  logic [15:0] cnt_r, cnt_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    unique case (state_r)
      fsuc_pkg::FSUC_IDLE, fsuc_pkg::FSUC_RUN: begin
        if (spinStart) begin
          state_nxt = fsuc_pkg::FSUC_SPIN;
          cnt_nxt = 16'h0000;
        end
      end
      fsuc_pkg::FSUC_SPIN: begin
        cnt_nxt = cnt_r + 16'h0001;
        if (cnt_nxt >= spinCycles) begin
          state_nxt = fsuc_pkg::FSUC_RUN;
        end else if (earlyExit && (tachReading > tachMinimum)) begin
          state_nxt = fsuc_pkg::FSUC_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_r <= fsuc_pkg::FSUC_IDLE;
      cnt_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign spinActive = (state_r == fsuc_pkg::FSUC_SPIN);

  property p_no_early_end;
    @(posedge clk_sys) disable iff (!resetn)
      (spinActive && !earlyExit && !spinStart && (cnt_r + 16'h0001 < spinCycles))
        |=> spinActive;
  endproperty
  a_no_early_end: assert property (p_no_early_end) else $error("spin ended early");

  property p_tach_exit;
    @(posedge clk_sys) disable iff (!resetn)
      (spinActive && earlyExit && (tachReading > tachMinimum)) |=> !spinActive;
  endproperty
  a_tach_exit: assert property (p_tach_exit) else $error("tach exit missed");
endmodule

// File: hw/fsuc_top.sv
/*
  fan spin-up exit mode and xor-tree test mode registers with three spin channels.
  assumes a serial bus slave presents one-cycle register requests on regReq.
*/
`timescale 1ns/10ps
`include "fsuc_cfg.svh"
module fsuc_top (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire fsuc_pkg::fsuc_regreq_t regReq,
  input wire logic lockBit,
  input wire logic startBit,
  input wire logic [2:0] spinStart,
  input wire logic [15:0] spinCycles,
  input wire logic [47:0] tachReading,
  input wire logic [15:0] tachMinimum,
  input wire logic [7:0] spinDuty,
  input wire logic [23:0] zoneDuty,
  input wire logic [15:0] testInputs,
  output logic [7:0] rdData,
  output logic [23:0] pwmDuty,
  output logic xorTreeEnable,
  output logic xorTreeOut,
  output logic [2:0] spinActive
);
  logic [7:0] spinMode_r, spinMode_nxt;
  logic xenReg_r, xenReg_nxt;
  logic [7:0] rdData_r, rdData_nxt;
  logic [23:0] pwmDuty_r, pwmDuty_nxt;
  logic xorOut_r, xorOut_nxt;
  logic [2:0] spinActive_r;
  logic [2:0] chanActive;
  logic [2:0] effMode;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // true for the two registers this block owns; every other address is undefined
  function automatic logic isDefinedAddr(input logic [7:0] a);
    return (a == `FSUC_ADDR_SPINUP) || (a == `FSUC_ADDR_TEST);
  endfunction

  // ----------------------------------------
  // register file
  // ----------------------------------------
  always_comb begin
    spinMode_nxt = spinMode_r;
    xenReg_nxt = xenReg_r;
    rdData_nxt = rdData_r;
    if (regReq.wrEn && !lockBit) begin
      if (regReq.addr == `FSUC_ADDR_SPINUP) begin
        spinMode_nxt = regReq.wrData & `FSUC_SPINUP_MASK;
      end else if (regReq.addr == `FSUC_ADDR_TEST) begin
        xenReg_nxt = regReq.wrData[`FSUC_XEN_BIT];
      end
      // other addresses: nothing stored, no error
    end
    if (regReq.rdEn) begin
      if (regReq.addr == `FSUC_ADDR_SPINUP) begin
        rdData_nxt = spinMode_r;
      end else if (regReq.addr == `FSUC_ADDR_TEST) begin
        rdData_nxt = {7'h00, xenReg_r};
      end else begin
        rdData_nxt = `FSUC_UNDEF_READ;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      spinMode_r <= `FSUC_SPINUP_RESET;
      xenReg_r <= 1'b0;
      rdData_r <= 8'h00;
    end else begin
      spinMode_r <= spinMode_nxt;
      xenReg_r <= xenReg_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  // default mode in force until start is set
  assign effMode = startBit ? spinMode_r[2:0] : 3'(`FSUC_SPINUP_RESET);

  // ----------------------------------------
  // spin channels
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `FSUC_CHANNELS; gi = gi + 1) begin : g_chan
      fsuc_spin_chan u_chan (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .spinStart(spinStart[gi]),
        .earlyExit(effMode[gi]),
        .spinCycles(spinCycles),
        .tachReading(tachReading[gi*16 +: 16]),
        .tachMinimum(tachMinimum),
        .spinActive(chanActive[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // outputs and xor tree
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pwmDuty_nxt[i*8 +: 8] = chanActive[i] ? spinDuty : zoneDuty[i*8 +: 8];
    end
    // bus pins are never among testInputs; parity is order free
    xorOut_nxt = xenReg_r ? ^testInputs : 1'b0;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pwmDuty_r <= 24'h0000_00;
      xorOut_r <= 1'b0;
      spinActive_r <= 3'h0;
    end else begin
      pwmDuty_r <= pwmDuty_nxt;
      xorOut_r <= xorOut_nxt;
      spinActive_r <= chanActive;
    end
  end

  assign rdData = rdData_r;
  assign pwmDuty = pwmDuty_r;
  assign xorTreeEnable = xenReg_r;
  assign xorTreeOut = xorOut_r;
  assign spinActive = spinActive_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_locked_write;
    regReq.wrEn && lockBit && regReq.addr == `FSUC_ADDR_SPINUP;
  endsequence

  property p_lock;
    @(posedge clk_sys) disable iff (!resetn) s_locked_write |=> $stable(spinMode_r);
  endproperty
  a_lock: assert property (p_lock) else $error("locked write changed mode");

  property p_undef_read;
    @(posedge clk_sys) disable iff (!resetn)
      (regReq.rdEn && !isDefinedAddr(regReq.addr))
        |=> rdData == 8'h00;
  endproperty
  a_undef_read: assert property (p_undef_read) else $error("undefined read not zero");

  property p_undef_write;
    @(posedge clk_sys) disable iff (!resetn)
      (regReq.wrEn && !isDefinedAddr(regReq.addr))
        |=> $stable(spinMode_r) && $stable(xenReg_r);
  endproperty
  a_undef_write: assert property (p_undef_write) else $error("undefined write stored");

  property p_xen_on;
    @(posedge clk_sys) disable iff (!resetn)
      (regReq.wrEn && !lockBit && regReq.addr == `FSUC_ADDR_TEST && regReq.wrData[0])
        |=> xorTreeEnable;
  endproperty
  a_xen_on: assert property (p_xen_on) else $error("test mode not entered");

  property p_xen_off;
    @(posedge clk_sys) disable iff (!resetn)
      (regReq.wrEn && !lockBit && regReq.addr == `FSUC_ADDR_TEST && !regReq.wrData[0])
        |=> !xorTreeEnable ##1 !xorTreeOut;
  endproperty
  a_xen_off: assert property (p_xen_off) else $error("test mode not left");

  property p_xor;
    @(posedge clk_sys) disable iff (!resetn) xorTreeEnable |=> xorTreeOut == $past(^testInputs);
  endproperty
  a_xor: assert property (p_xor) else $error("xor tree mismatch");

  property p_mode_write;
    @(posedge clk_sys) disable iff (!resetn)
      (regReq.wrEn && !lockBit && regReq.addr == `FSUC_ADDR_SPINUP)
        |=> spinMode_r == {5'h00, $past(regReq.wrData[2:0])};
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode write lost");

  property p_default_mode;
    @(posedge clk_sys) disable iff (!resetn) !startBit |-> effMode == 3'h7;
  endproperty
  a_default_mode: assert property (p_default_mode) else $error("default not used");

  property p_duty;
    @(posedge clk_sys) disable iff (!resetn) chanActive[0] |=> pwmDuty[7:0] == $past(spinDuty);
  endproperty
  a_duty: assert property (p_duty) else $error("spin duty missing");

  // ----------------------------------------
  // further register and output checks
  // ----------------------------------------
  property p_mode_read;
    @(posedge clk_sys) disable iff (!resetn)
      (regReq.rdEn && regReq.addr == `FSUC_ADDR_SPINUP)
        |=> rdData == {5'h00, $past(spinMode_r[2:0])};
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode read wrong");

  property p_mode_reserved;
    @(posedge clk_sys) disable iff (!resetn) spinMode_r[7:3] == 5'h00;
  endproperty
  a_mode_reserved: assert property (p_mode_reserved) else $error("reserved bits set");

  property p_test_read;
    @(posedge clk_sys) disable iff (!resetn)
      (regReq.rdEn && regReq.addr == `FSUC_ADDR_TEST)
        |=> rdData == {7'h00, $past(xenReg_r)};
  endproperty
  a_test_read: assert property (p_test_read) else $error("test read wrong");

  property p_test_lock;
    @(posedge clk_sys) disable iff (!resetn)
      (regReq.wrEn && lockBit && regReq.addr == `FSUC_ADDR_TEST) |=> $stable(xenReg_r);
  endproperty
  a_test_lock: assert property (p_test_lock) else $error("locked test write stored");

  property p_read_hold;
    @(posedge clk_sys) disable iff (!resetn) !regReq.rdEn |=> $stable(rdData);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read data changed");

  property p_xor_idle;
    @(posedge clk_sys) disable iff (!resetn) !xenReg_r |=> !xorTreeOut;
  endproperty
  a_xor_idle: assert property (p_xor_idle) else $error("xor out while disabled");

  property p_duty1;
    @(posedge clk_sys) disable iff (!resetn)
      chanActive[1] |=> pwmDuty[15:8] == $past(spinDuty);
  endproperty
  a_duty1: assert property (p_duty1) else $error("spin duty missing on output 2");

  property p_duty2;
    @(posedge clk_sys) disable iff (!resetn)
      chanActive[2] |=> pwmDuty[23:16] == $past(spinDuty);
  endproperty
  a_duty2: assert property (p_duty2) else $error("spin duty missing on output 3");

  property p_zone0;
    @(posedge clk_sys) disable iff (!resetn)
      !chanActive[0] |=> pwmDuty[7:0] == $past(zoneDuty[7:0]);
  endproperty
  a_zone0: assert property (p_zone0) else $error("zone duty missing");

  property p_active_follow;
    @(posedge clk_sys) disable iff (!resetn) 1'b1 |=> spinActive == $past(chanActive);
  endproperty
  a_active_follow: assert property (p_active_follow) else $error("spin state not shown");
endmodule

// File: verif/fsuc_host.sv
/*
  serial bus host model issuing single-byte register requests.
  assumes requests are taken on the rising clk_sys edge, read data one cycle later.
*/
`timescale 1ns/10ps
module fsuc_host (
  input wire logic clk_sys,
  input wire logic [7:0] rdData,
  output fsuc_pkg::fsuc_regreq_t regReq
);
  initial regReq = '0;
  // ----------------------------------------
  // one transfer: hold for one edge, then release
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clk_sys);
    #1;
    regReq = {w, ~w, a, d};
    @(posedge clk_sys);
    #1;
    // released address and data lines must not look valid
    regReq = {2'b00, ~a, ~d};
    @(posedge clk_sys);
    #1;
    q = rdData;
  endtask
endmodule

// File: verif/fan_spinup_and_test_mode_ctrl_bench.sv
/*
  self-checking bench for the spin-up mode and test mode register block.
  assumes fsuc_pkg is compiled first and the host model drives all requests.
*/
`timescale 1ns/10ps
module fan_spinup_and_test_mode_ctrl_bench;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  fsuc_pkg::fsuc_regreq_t regReq;
  logic lockBit = 1'b0;
  logic startBit = 1'b1;
  logic [2:0] spinStart = 3'b000;
  logic [15:0] testInputs = 16'h0007;
  logic [47:0] tachReading = 48'h0200_0200_0200;
  logic [23:0] zoneDuty = 24'h30_2010;
  logic [7:0] spinDuty = 8'hc0;
  logic [7:0] rdData;
  logic [7:0] q;
  logic [23:0] pwmDuty;
  logic xorTreeEnable;
  logic xorTreeOut;
  logic [2:0] spinActive;
  int nMismatch = 0;
  int compares = 0;

  initial forever #50 clk_sys = ~clk_sys;

  fsuc_host host (.clk_sys(clk_sys), .rdData(rdData), .regReq(regReq));
  fsuc_top DUT (.clk_sys(clk_sys), .resetn(resetn), .regReq(regReq), .lockBit(lockBit),
    .startBit(startBit), .spinStart(spinStart), .spinCycles(16'h0014),
    .tachReading(tachReading), .tachMinimum(16'h0080), .spinDuty(spinDuty),
    .zoneDuty(zoneDuty), .testInputs(testInputs), .rdData(rdData), .pwmDuty(pwmDuty),
    .xorTreeEnable(xorTreeEnable), .xorTreeOut(xorTreeOut), .spinActive(spinActive));

  // ----------------------------------------
  // checking and access tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host.xfer(1'b0, a, 8'h00, q);
    chk("rdData", {8'h00, q}, {8'h00, e});
  endtask

  task automatic spin(input int ch, input logic early);
    int c;
    c = 0;
    spinStart[ch] = 1'b1;
    @(posedge clk_sys);
    #1;
    spinStart = 3'b000;
    repeat (60) begin
      @(posedge clk_sys);
      #1;
      if (spinActive[ch] === 1'b1) begin
        c++;
        chk("spinDuty", {8'h00, pwmDuty[ch*8+:8]}, {8'h00, spinDuty});
      end
    end
    chk("zoneDuty", {8'h00, pwmDuty[ch*8+:8]}, {8'h00, zoneDuty[ch*8+:8]});
    if (early)
      chk("earlyExit", {15'h0000, c < 20}, 16'h0001);
    else
      chk("spinLength", c[15:0], 16'h0014);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", compares, nMismatch);
    if (nMismatch == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    rd(8'h75, 8'h07);
    rd(8'h6f, 8'h00);
    host.xfer(1'b1, 8'h75, 8'hfa, q);
    rd(8'h75, 8'h02);
    lockBit = 1'b1;
    host.xfer(1'b1, 8'h75, 8'h05, q);
    rd(8'h75, 8'h02);
    lockBit = 1'b0;
    host.xfer(1'b1, 8'h76, 8'hff, q);
    rd(8'h76, 8'h00);
    rd(8'h75, 8'h02);
    startBit = 1'b0;
    spin(0, 1'b1);
    startBit = 1'b1;
    spin(0, 1'b0);
    spin(1, 1'b1);
    spin(2, 1'b0);
    host.xfer(1'b1, 8'h6f, 8'h01, q);
    chk("xorTreeEnable", {15'h0000, xorTreeEnable}, 16'h0001);
    chk("xorTreeOut", {15'h0000, xorTreeOut}, 16'h0001);
    testInputs = 16'h8421;
    @(posedge clk_sys);
    #1;
    @(posedge clk_sys);
    #1;
    chk("xorTreeOut", {15'h0000, xorTreeOut}, 16'h0000);
    host.xfer(1'b1, 8'h6f, 8'h00, q);
    chk("xorTreeEnable", {15'h0000, xorTreeEnable}, 16'h0000);
    finish_test();
  end
endmodule
